// *** logic/gpio_pkg.sv ***
// Constants, register map and port layout of the parallel I/O block.
// Assumes a single 10 MHz clock; one state time is one clock cycle.
// Functional notes
// RL1: Every pin level is sampled into its input latch each state time.
// RL2: Input pin: write updates output latch only; read returns sampled pin.
// RL3: Input pin: read-modify-write uses sampled pin, stores into output latch.
// RL4: Output pin: buffer enabled, write sets latch and pin, read gives latch.
// RL5: Output pin: read-modify-write uses latch, writes back, changes pin.
// RL6: Ports 2,3,4,6,7,8 have per-bit push-pull or open-drain select.
// RL7: Open drain drives low for zero and releases pin for one.
// RL8: One threshold bit per byte; 16-bit ports 0,1,2,3,5 use two.
// RL9: Direction and output mode work alike under any threshold setting.
// RL10: Port 3 lacks bit 14; port 5 is input only, no drivers.
// RL11: Alternate output reaches pin only when direction is output.
// RL12: Latch is ANDed with alternate output except PWM; software keeps one.
// RL13: Direction bits reset to input; some signals get automatic direction.
// RL14: Output pin with alternate input: that input sees the output latch.
// RL15: Hardware switches direction itself for bus-style alternate functions.
// RL16: Software sets direction before enabling an alternate function.
// RL17: Software sets input direction when an external device drives.
package gpio_pkg;
  localparam int NPORT = 9;
  localparam int PW = 16;
  localparam int ADDR_W = 8;
  // Implemented lines per port; port 3 has no bit 14
  localparam logic [PW-1:0] PORT_MASK [NPORT] = '{
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hBFFF, 16'h00FF,
    16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF};
  // Ports with open-drain select: 2,3,4,6,7,8
  localparam logic [NPORT-1:0] OD_PORTS = 9'h1DC;
  // Ports without output drivers: 5
  localparam logic [NPORT-1:0] IN_ONLY_PORTS = 9'h020;
  // Per-port register window and word offsets inside it
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_DIR = 4'h4;
  localparam logic [3:0] OFS_OD = 4'h8;
  localparam logic [3:0] OFS_RMW = 4'hC;
  localparam logic [ADDR_W-1:0] THR_ADDR = 8'h90;
  localparam logic [ADDR_W-1:0] THR_EXT_ADDR = 8'h94;
  // Threshold bit index per port byte into {ext[7:0], base[7:0]}
  localparam logic [3:0] THR_IDX [NPORT][2] = '{
    '{4'h8, 4'h9}, '{4'hA, 4'hB}, '{4'h0, 4'h1}, '{4'h2, 4'h3},
    '{4'h4, 4'h4}, '{4'h5, 4'h6}, '{4'h7, 4'h7}, '{4'hC, 4'hC},
    '{4'hD, 4'hD}};
  localparam logic [PW-1:0] LATCH_RST = 16'h0000;
  localparam logic [PW-1:0] DIR_RST = 16'h0000;
  localparam logic [PW-1:0] OD_RST = 16'h0000;
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : gpio_pkg

// *** logic/gpio_port_if.sv ***
// Carrier between the register side and the pad logic of one port.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface gpio_port_if #(parameter int W = 16);
  logic [W-1:0] latch;
  logic [W-1:0] dir;
  logic [W-1:0] od_sel;
  logic [W-1:0] alt_out;
  logic [W-1:0] alt_en;
  logic [W-1:0] alt_pwm;
  logic [W-1:0] hw_dir_en;
  logic [W-1:0] hw_dir;
  logic [W-1:0] pin_sync;
  logic [W-1:0] pin_o;
  logic [W-1:0] pin_oe;
  logic [W-1:0] alt_in;
  modport ctrl (output latch, dir, od_sel, alt_out, alt_en, alt_pwm,
    hw_dir_en, hw_dir, pin_sync, input pin_o, pin_oe, alt_in);
  modport pad (input latch, dir, od_sel, alt_out, alt_en, alt_pwm,
    hw_dir_en, hw_dir, pin_sync, output pin_o, pin_oe, alt_in);
endinterface : gpio_port_if

// *** logic/port_drive_logic.sv ***
// Pad-side logic of one port: driver enables, open drain, alternate paths.
// Assumes control and synced pin levels come in on the same clock.
`timescale 1ns/1ps
module port_drive_logic
  import gpio_pkg::*;
#(
  parameter int W = 16,
  parameter logic [W-1:0] MASK = '1,
  parameter bit HAS_OD = 1'b0,
  parameter bit IN_ONLY = 1'b0
) (
  input wire logic clk,
  input wire logic srst,
  gpio_port_if.pad pif
);
  logic [W-1:0] eff_dir;
  logic [W-1:0] data_out;
  logic [W-1:0] drive;
  logic [W-1:0] od_eff;
  logic [W-1:0] pin_o_q;
  logic [W-1:0] pin_oe_q;
  logic [W-1:0] alt_in_q;

  // Hardware may take over direction while a bus function runs
  assign eff_dir = (pif.hw_dir_en & pif.hw_dir) |
    (~pif.hw_dir_en & pif.dir); // RL15 RL13
  // Non-PWM alternate data is gated by the latch, so it must hold one
  assign data_out = (pif.alt_en & pif.alt_pwm & pif.alt_out) |
    (pif.alt_en & ~pif.alt_pwm & pif.alt_out & pif.latch) |
    (~pif.alt_en & pif.latch); // RL12
  // Missing lines and input-only ports never drive
  assign drive = IN_ONLY ? '0 : (eff_dir & MASK); // RL10 RL11
  assign od_eff = HAS_OD ? pif.od_sel : '0; // RL6 RL9

  // Output drivers, registered so pins never glitch on decode
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_o_q <= '0;
      pin_oe_q <= '0;
    end else begin
      pin_o_q <= data_out & ~od_eff; // RL7
      pin_oe_q <= drive & ~(od_eff & data_out); // RL7 RL4
    end
  end

  // Alternate input follows the latch when the pin is an output
  always_ff @(posedge clk) begin
    if (srst) begin
      alt_in_q <= '0;
    end else begin
      alt_in_q <= (eff_dir & pif.latch) | (~eff_dir & pif.pin_sync); // RL14
    end
  end

  assign pif.pin_o = pin_o_q;
  assign pif.pin_oe = pin_oe_q;
  assign pif.alt_in = alt_in_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_od_release;
    ##1 (pin_oe_q & $past(od_eff & data_out)) == '0;
  endproperty
  a_od_release: assert property (p_od_release) // RL7
    else $error("open drain pin driven high");
  property p_od_ports;
    !HAS_OD |-> ((pin_oe_q & ~pin_o_q & $past(pif.latch) &
      ~$past(pif.alt_en) & $past(drive)) == '0);
  endproperty
  a_od_ports: assert property (p_od_ports) // RL6
    else $error("open drain acted on a push-pull only port");
  property p_no_driver;
    (pin_oe_q & ~MASK) == '0 && (!IN_ONLY || pin_oe_q == '0);
  endproperty
  a_no_driver: assert property (p_no_driver) // RL10
    else $error("absent or input-only line driven");
  property p_dir_gate;
    ##1 (pin_oe_q & ~$past(eff_dir)) == '0;
  endproperty
  a_dir_gate: assert property (p_dir_gate) // RL11
    else $error("pin driven while direction is input");
  property p_and_gate;
    ##1 (pin_o_q & $past(pif.alt_en & ~pif.alt_pwm & ~pif.latch)) == '0;
  endproperty
  a_and_gate: assert property (p_and_gate) // RL12
    else $error("alternate output not gated by latch");
  property p_alt_in;
    ##1 alt_in_q == $past((eff_dir & pif.latch) |
      (~eff_dir & pif.pin_sync));
  endproperty
  a_alt_in: assert property (p_alt_in) // RL14
    else $error("alternate input source wrong");
  property p_hw_dir;
    ##1 (pin_oe_q & $past(pif.hw_dir_en & ~pif.hw_dir)) == '0;
  endproperty
  a_hw_dir: assert property (p_hw_dir) // RL15
    else $error("hardware input direction ignored");
endmodule : port_drive_logic

// *** logic/gpio_port_block.sv ***
// Parallel I/O ports with an AHB-Lite register slave.
// Assumes pins are asynchronous and alternate signals share clk.
`timescale 1ns/1ps
module gpio_port_block
  import gpio_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NPORT-1:0][PW-1:0] pin_i,
  output logic [NPORT-1:0][PW-1:0] pin_o,
  output logic [NPORT-1:0][PW-1:0] pin_oe,
  input wire logic [NPORT-1:0][PW-1:0] alt_out,
  input wire logic [NPORT-1:0][PW-1:0] alt_en,
  input wire logic [NPORT-1:0][PW-1:0] alt_pwm,
  input wire logic [NPORT-1:0][PW-1:0] hw_dir_en,
  input wire logic [NPORT-1:0][PW-1:0] hw_dir,
  output logic [NPORT-1:0][PW-1:0] alt_in,
  output logic [NPORT-1:0][1:0] thr_cmos
);
  logic [NPORT-1:0][PW-1:0] pin_meta_q;
  logic [NPORT-1:0][PW-1:0] pin_sync_q;
  logic [NPORT-1:0][PW-1:0] latch_q;
  logic [NPORT-1:0][PW-1:0] dir_q;
  logic [NPORT-1:0][PW-1:0] od_q;
  logic [7:0] thr_base_q;
  logic [7:0] thr_ext_q;
  logic [NPORT-1:0][1:0] thr_cmos_q;
  logic [ADDR_W-1:0] addr_q;
  logic write_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_val;
  logic [15:0] thr_all;
  logic accept;
  logic busy;
  logic wr_go;
  logic [3:0] port_idx;
  logic [3:0] reg_ofs;
  logic port_hit;

  // Address phase is taken only for active transfers with the bus ready
  assign accept = hsel && hready && htrans == HTRANS_NONSEQ;
  assign busy = !hreadyout_q;
  assign wr_go = busy && write_q;
  assign port_idx = addr_q[7:4];
  assign reg_ofs = addr_q[3:0];
  assign port_hit = 32'(port_idx) < NPORT;
  assign thr_all = {thr_ext_q, thr_base_q};

  // One wait state per transfer lets read data leave from a flop
  always_ff @(posedge clk) begin
    if (srst) begin
      hreadyout_q <= 1'b1;
      addr_q <= '0;
      write_q <= 1'b0;
    end else if (accept) begin
      hreadyout_q <= 1'b0;
      addr_q <= haddr[ADDR_W-1:0];
      write_q <= hwrite;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  // Two-stage pin synchroniser; second stage is the input latch
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= pin_i;
      pin_sync_q <= pin_meta_q; // RL1
    end
  end

  // Read mux: pin level for inputs, latch for outputs
  always_comb begin
    rd_val = 32'h0000_0000;
    if (port_hit) begin
      unique case (reg_ofs)
        OFS_DATA, OFS_RMW: rd_val[PW-1:0] =
          ((dir_q[port_idx] & latch_q[port_idx]) |
           (~dir_q[port_idx] & pin_sync_q[port_idx])) &
          PORT_MASK[port_idx]; // RL2 RL4
        OFS_DIR: rd_val[PW-1:0] = dir_q[port_idx];
        OFS_OD: rd_val[PW-1:0] = od_q[port_idx];
        default: rd_val = 32'h0000_0000;
      endcase
    end else if (addr_q == THR_ADDR) begin
      rd_val[7:0] = thr_base_q;
    end else if (addr_q == THR_EXT_ADDR) begin
      rd_val[7:0] = thr_ext_q;
    end
  end

  // Read data register; holds its value between reads
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (busy && !write_q) begin
      hrdata_q <= rd_val;
    end
  end

  // Threshold select, one bit per port byte
  always_ff @(posedge clk) begin
    if (srst) begin
      thr_base_q <= THR_RST;
      thr_ext_q <= THR_RST;
    end else if (wr_go && addr_q == THR_ADDR) begin
      thr_base_q <= hwdata[7:0]; // RL8
    end else if (wr_go && addr_q == THR_EXT_ADDR) begin
      thr_ext_q <= hwdata[7:0]; // RL8
    end
  end

  // Per-port control registers and pad logic
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    localparam logic [PW-1:0] DRV_MASK =
      IN_ONLY_PORTS[p] ? 16'h0000 : PORT_MASK[p];
    localparam logic [PW-1:0] OD_MASK =
      OD_PORTS[p] ? PORT_MASK[p] : 16'h0000;
    logic sel;
    logic [PW-1:0] rmw_src;
    gpio_port_if #(.W(PW)) pif ();

    assign sel = wr_go && port_hit && port_idx == 4'(p);
    // Modify source follows the pin's direction
    assign rmw_src = (dir_q[p] & latch_q[p]) |
      (~dir_q[p] & pin_sync_q[p]); // RL3 RL5

    // Writes land in the latch whatever the direction
    always_ff @(posedge clk) begin
      if (srst) begin
        latch_q[p] <= LATCH_RST;
      end else if (sel && reg_ofs == OFS_DATA) begin
        latch_q[p] <= hwdata[PW-1:0] & PORT_MASK[p]; // RL2 RL4
      end else if (sel && reg_ofs == OFS_RMW) begin
        latch_q[p] <= ((rmw_src & ~hwdata[31:16]) | hwdata[PW-1:0]) &
          PORT_MASK[p]; // RL3 RL5
      end
    end

    // Direction resets to input on every line
    always_ff @(posedge clk) begin
      if (srst) begin
        dir_q[p] <= DIR_RST; // RL13
      end else if (sel && reg_ofs == OFS_DIR) begin
        dir_q[p] <= hwdata[PW-1:0] & DRV_MASK; // RL10
      end
    end

    // Open-drain select exists only on the listed ports
    always_ff @(posedge clk) begin
      if (srst) begin
        od_q[p] <= OD_RST;
      end else if (sel && reg_ofs == OFS_OD) begin
        od_q[p] <= hwdata[PW-1:0] & OD_MASK; // RL6
      end
    end

    // Pad-facing threshold levels; both bits equal on 8-bit ports
    always_ff @(posedge clk) begin
      if (srst) begin
        thr_cmos_q[p] <= 2'b00;
      end else begin
        thr_cmos_q[p] <= {thr_all[THR_IDX[p][1]],
          thr_all[THR_IDX[p][0]]}; // RL8
      end
    end

    assign pif.latch = latch_q[p];
    assign pif.dir = dir_q[p];
    assign pif.od_sel = od_q[p]; // RL9
    assign pif.alt_out = alt_out[p];
    assign pif.alt_en = alt_en[p];
    assign pif.alt_pwm = alt_pwm[p];
    assign pif.hw_dir_en = hw_dir_en[p] & DRV_MASK;
    assign pif.hw_dir = hw_dir[p];
    assign pif.pin_sync = pin_sync_q[p];

    port_drive_logic #(
      .W(PW),
      .MASK(PORT_MASK[p]),
      .HAS_OD(OD_PORTS[p]),
      .IN_ONLY(IN_ONLY_PORTS[p])
    ) u_drive (
      .clk(clk),
      .srst(srst),
      .pif(pif)
    );

    assign pin_o[p] = pif.pin_o;
    assign pin_oe[p] = pif.pin_oe;
    assign alt_in[p] = pif.alt_in;
  end

  assign hreadyout = hreadyout_q;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_q;
  assign thr_cmos = thr_cmos_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_wr_port(logic [3:0] ofs);
    busy && write_q && port_hit && reg_ofs == ofs;
  endsequence
  sequence s_rd_data;
    busy && !write_q && port_hit && reg_ofs == OFS_DATA;
  endsequence

  property p_sample;
    !$past(srst) && !$past(srst, 2) |-> pin_sync_q == $past(pin_i, 2);
  endproperty
  a_sample: assert property (p_sample) // RL1
    else $error("input latch missed a pin sample");
  property p_wr_latch;
    s_wr_port(OFS_DATA) |=> latch_q[$past(port_idx)] ==
      ($past(hwdata[PW-1:0]) & PORT_MASK[$past(port_idx)]);
  endproperty
  a_wr_latch: assert property (p_wr_latch) // RL2
    else $error("write did not reach output latch");
  property p_rd_src;
    s_rd_data |=> hrdata_q[PW-1:0] == $past(
      ((dir_q[port_idx] & latch_q[port_idx]) |
       (~dir_q[port_idx] & pin_sync_q[port_idx])) & PORT_MASK[port_idx]);
  endproperty
  a_rd_src: assert property (p_rd_src) // RL4
    else $error("read source does not follow direction");
  property p_rmw;
    s_wr_port(OFS_RMW) |=> latch_q[$past(port_idx)] == $past(
      ((((dir_q[port_idx] & latch_q[port_idx]) |
         (~dir_q[port_idx] & pin_sync_q[port_idx])) & ~hwdata[31:16]) |
       hwdata[PW-1:0]) & PORT_MASK[port_idx]);
  endproperty
  a_rmw: assert property (p_rmw) // RL3 RL5
    else $error("read-modify-write used wrong source");
  property p_pin_follows;
    s_wr_port(OFS_DATA) ##0 (dir_q[port_idx] == PORT_MASK[port_idx]) &&
      (od_q[port_idx] == '0) && (alt_en[port_idx] == '0) &&
      (hw_dir_en[port_idx] == '0) && port_idx != 4'h5
      ##1 !accept && !busy ##1 1'b1 |=>
      pin_oe[$past(port_idx, 3)] == PORT_MASK[$past(port_idx, 3)];
  endproperty
  a_pin_follows: assert property (p_pin_follows) // RL4
    else $error("output pin not enabled after write");
  property p_dir_reset;
    $past(srst) |-> dir_q == '0;
  endproperty
  a_dir_reset: assert property (p_dir_reset) // RL13
    else $error("direction not input after reset");
  property p_thr;
    ##1 thr_cmos_q[2] == $past(thr_base_q[1:0]) &&
      thr_cmos_q[4][0] == thr_cmos_q[4][1];
  endproperty
  a_thr: assert property (p_thr) // RL8
    else $error("threshold select misrouted");
  property p_bus;
    accept |=> !hreadyout ##1 hreadyout && hresp == HRESP_OKAY;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus wait state wrong");

  // Read data must stand until the next read loads it
  property p_rd_hold;
    !(busy && !write_q) |=> $stable(hrdata_q);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed outside a read");
  // Without a new transfer the bus is ready again next cycle
  property p_ready_idle;
    !accept |=> hreadyout;
  endproperty
  a_ready_idle: assert property (p_ready_idle)
    else $error("ready not restored when idle");

  // The input latch is the second synchroniser stage
  property p_sync_chain;
    ##1 pin_sync_q == $past(pin_meta_q);
  endproperty
  a_sync_chain: assert property (p_sync_chain) // RL1
    else $error("input latch skipped a stage");

  // Absent line 14 of port 3 never holds state
  property p_p3_gap;
    !latch_q[3][14] && !dir_q[3][14] && !od_q[3][14];
  endproperty
  a_p3_gap: assert property (p_p3_gap) // RL10
    else $error("absent port 3 line holds state");
  // Port 5 has no drivers, so nothing may turn one on
  property p_p5_in;
    dir_q[5] == '0 && od_q[5] == '0 && pin_oe[5] == '0;
  endproperty
  a_p5_in: assert property (p_p5_in) // RL10
    else $error("input-only port enabled a driver");
  // Push-pull only ports keep their open-drain bits clear
  property p_od_mask;
    od_q[0] == '0 && od_q[1] == '0 && od_q[5] == '0;
  endproperty
  a_od_mask: assert property (p_od_mask) // RL6
    else $error("open drain set on a push-pull port");
  property p_wr_od;
    s_wr_port(OFS_OD) ##0 port_idx == 4'h2 |=>
      od_q[2] == $past(hwdata[PW-1:0]);
  endproperty
  a_wr_od: assert property (p_wr_od) // RL6
    else $error("open drain select not written");

  // Extension byte routes to port 0, and 8-bit ports copy one bit
  property p_thr_ext;
    ##1 thr_cmos_q[0] == $past(thr_ext_q[1:0]);
  endproperty
  a_thr_ext: assert property (p_thr_ext) // RL8
    else $error("port 0 threshold misrouted");
  property p_thr_8bit;
    ##1 thr_cmos_q[7] == {2{$past(thr_ext_q[4])}};
  endproperty
  a_thr_8bit: assert property (p_thr_8bit) // RL8
    else $error("8-bit port threshold misrouted");

  // Direction writes land masked to implemented lines
  property p_wr_dir;
    s_wr_port(OFS_DIR) ##0 port_idx != 4'h5 |=>
      dir_q[$past(port_idx)] ==
      ($past(hwdata[PW-1:0]) & PORT_MASK[$past(port_idx)]);
  endproperty
  a_wr_dir: assert property (p_wr_dir) // RL4
    else $error("direction write did not land");
endmodule : gpio_port_block

// *** verif/pin_partner.sv ***
// Pad-side partner: external devices plus a pull-up on every pad.
// Assumes pin_o/pin_oe come registered from the block under test.
`timescale 1ns/1ps
module pin_partner
  import gpio_pkg::*;
(
  input wire logic [NPORT-1:0][PW-1:0] pin_o,
  input wire logic [NPORT-1:0][PW-1:0] pin_oe,
  input wire logic [NPORT-1:0][PW-1:0] ext_val,
  input wire logic [NPORT-1:0][PW-1:0] ext_on,
  output logic [NPORT-1:0][PW-1:0] pin_i
);
  // Devices only drive released pads, so no pad ever sees a fight
  // Undriven pads float up through the pull-up, as open drain expects
  assign pin_i = (pin_oe & pin_o) |
    (~pin_oe & ((ext_on & ext_val) | ~ext_on));
endmodule : pin_partner

// *** verif/testbench.sv ***
// Self-checking bench for the parallel I/O block over AHB-Lite.
// Assumes one wait state per transfer; pads resolved by pin_partner.
`timescale 1ns/1ps
module testbench
  import gpio_pkg::*;
;
  typedef logic [NPORT-1:0][PW-1:0] bus_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  bus_t pin_i, pin_o, pin_oe, alt_in;
  bus_t alt_out = '0, alt_en = '0, alt_pwm = '0;
  bus_t hw_dir_en = '0, hw_dir = '0, ext_val = '0, ext_on = '0;
  logic [NPORT-1:0][1:0] thr_cmos;
  int errors = 0;
  int checks_done = 0;
  bit rd_pend = 1'b0;
  logic [39:0] exp_q[$];
  logic [31:0] rnd = 32'd84019;

  // 100 ns period
  always #50 clk = ~clk;

  gpio_port_block dut_u (.clk(clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .alt_out(alt_out), .alt_en(alt_en),
    .alt_pwm(alt_pwm), .hw_dir_en(hw_dir_en), .hw_dir(hw_dir),
    .alt_in(alt_in), .thr_cmos(thr_cmos));

  pin_partner peer_u (.pin_o(pin_o), .pin_oe(pin_oe),
    .ext_val(ext_val), .ext_on(ext_on), .pin_i(pin_i));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'hA3000000) : (x >> 1);
  endfunction : lfsr

  function automatic logic [7:0] adr(input int p, input logic [3:0] o);
    return {4'(p), o};
  endfunction : adr

  task automatic print_verdict;
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Bounded wait for hready; a hang counts as a mismatch
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        print_verdict;
      end
      @(posedge clk);
    end
  endtask : wait_ready

  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  // Expectation is queued before the address goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({a, e});
    ahb(1'b0, a, 32'h0);
  endtask : rd

  task automatic settle;
    repeat (4) @(posedge clk);
  endtask : settle

  // Read monitor: pairs each completed read with the oldest note
  always @(posedge clk) begin
    logic [39:0] n;
    if (rd_pend && hreadyout === 1'b1) begin
      rd_pend = 1'b0;
      n = exp_q.pop_front();
      chk($sformatf("hrdata at %h", n[39:32]), n[31:0], hrdata);
      chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    end
    if (hsel && hreadyout && htrans == HTRANS_NONSEQ && !hwrite)
      rd_pend = 1'b1;
  end

  initial begin
    logic [15:0] m, v, x, s, c, e;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // Per port: input reads the pad, output reads and drives the latch
    for (int p = 0; p < NPORT; p++) begin
      m = PORT_MASK[p];
      rnd = lfsr(rnd);
      v = rnd[15:0];
      x = rnd[31:16];
      chk("pin_oe", 32'h0, pin_oe[p]);
      rd(adr(p, OFS_DIR), 32'h0);
      ext_on[p] <= 16'hFFFF;
      ext_val[p] <= x;
      wr(adr(p, OFS_DATA), {16'h0, v});
      settle;
      rd(adr(p, OFS_DATA), {16'h0, x & m});
      wr(adr(p, OFS_DIR), 32'hFFFF);
      settle;
      e = IN_ONLY_PORTS[p] ? 16'h0 : m;
      rd(adr(p, OFS_DIR), {16'h0, e});
      chk("pin_oe", {16'h0, e}, pin_oe[p]);
      rd(adr(p, OFS_DATA), {16'h0, (e & v) | (~e & x & m)});
      if (!IN_ONLY_PORTS[p]) chk("pin_o", {16'h0, v & m}, pin_o[p]);
    end
    // Set/clear on an output pin starts from the latch and moves the pad
    rnd = lfsr(rnd);
    {c, s} = rnd;
    wr(adr(2, OFS_DATA), {16'h0, x});
    wr(adr(2, OFS_RMW), {c, s});
    rd(adr(2, OFS_DATA), {16'h0, (x & ~c) | s});
    settle;
    chk("pin_o", {16'h0, (x & ~c) | s}, pin_o[2]);
    // On an input pin it starts from the sampled pad instead
    rnd = lfsr(rnd);
    {c, s} = rnd;
    wr(adr(2, OFS_DIR), 32'h0);
    ext_val[2] <= v;
    settle;
    wr(adr(2, OFS_RMW), {c, s});
    wr(adr(2, OFS_DIR), 32'hFFFF);
    rd(adr(2, OFS_DATA), {16'h0, (v & ~c) | s});
    // Thresholds first, so the drive checks below run under them
    rnd = lfsr(rnd);
    s = rnd[15:0];
    wr(THR_ADDR, {24'h0, s[7:0]});
    wr(THR_EXT_ADDR, {24'h0, s[15:8]});
    rd(THR_ADDR, {24'h0, s[7:0]});
    rd(THR_EXT_ADDR, {24'h0, s[15:8]});
    settle;
    for (int p = 0; p < NPORT; p++)
      for (int b = 0; b < 2; b++)
        chk("thr_cmos", {31'h0, s[THR_IDX[p][b]]},
          {31'h0, thr_cmos[p][b]});
    // Open drain everywhere: only the six capable ports take it
    for (int p = 0; p < NPORT; p++) begin
      m = PORT_MASK[p];
      rnd = lfsr(rnd);
      v = rnd[15:0];
      wr(adr(p, OFS_DATA), {16'h0, v});
      wr(adr(p, OFS_OD), 32'hFFFF);
      // Devices let go so released pads show the pull-up
      ext_on[p] <= 16'h0000;
      settle;
      rd(adr(p, OFS_OD), {16'h0, OD_PORTS[p] ? m : 16'h0});
      e = IN_ONLY_PORTS[p] ? 16'h0 : (OD_PORTS[p] ? (~v & m) : m);
      chk("pin_oe", {16'h0, e}, pin_oe[p]);
      if (OD_PORTS[p]) chk("pin_o", 32'h0, pin_o[p]);
      if (OD_PORTS[p]) chk("pad", {16'h0, v & m}, pin_i[p] & m);
    end
    // Alternate path on port 7; direction is set before enabling it
    wr(adr(7, OFS_OD), 32'h0);
    wr(adr(7, OFS_DATA), 32'h0F);
    wr(adr(7, OFS_DIR), 32'h0);
    ext_val[7] <= 16'h3C;
    ext_on[7] <= 16'hFFFF;
    alt_en[7] <= 16'hFF;
    alt_out[7] <= 16'hFF;
    settle;
    chk("pin_oe", 32'h0, pin_oe[7]);
    chk("alt_in", 32'h3C, alt_in[7]);
    wr(adr(7, OFS_DIR), 32'hFF);
    settle;
    chk("pin_o", 32'h0F, pin_o[7]);
    chk("alt_in", 32'h0F, alt_in[7]);
    alt_pwm[7] <= 16'hFF;
    settle;
    chk("pin_o", 32'hFF, pin_o[7]);
    // Hardware direction overrides the register both ways
    wr(adr(0, OFS_DIR), 32'h0);
    hw_dir_en[0] <= 16'hFFFF;
    hw_dir[0] <= 16'hFFFF;
    settle;
    chk("pin_oe", 32'hFFFF, pin_oe[0]);
    wr(adr(0, OFS_DIR), 32'hFFFF);
    hw_dir[0] <= 16'h0;
    settle;
    chk("pin_oe", 32'h0, pin_oe[0]);
    // Unmapped word: write dropped, reads zero
    wr(8'hA0, 32'hFFFFFFFF);
    rd(8'hA0, 32'h0);
    // Reset in mid-run returns every pad to input
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int p = 0; p < NPORT; p++) chk("pin_oe", 32'h0, pin_oe[p]);
    rd(adr(3, OFS_DIR), 32'h0);
    settle;
    chk("reads left", 32'h0, 32'(exp_q.size()));
    print_verdict;
  end
endmodule : testbench
